/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import tise_pkg::*;
   typedef struct packed {
      logic [2:0] ev;
      logic [7:0] en1, en2, sa, exp1, exp2;
      logic irq;
   } tise_row_t;
   localparam int unsigned SC = 8;
   logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0] htrans;
   logic [2:0] hsize, hclr = 3'h0;
   logic hreadyout, hresp, irq_n, xtal = 1'b0, tx = 1'b0, idle = 1'b0;
   logic [7:0] evt = 8'h00;
   int n_errors = 0, check_count = 0, cyc = 0;
   // Event order: por, wake-up, fifo error, ext, sent, full, empty, battery
   tise_row_t rows [9] = '{
      '{3'd0, 8'h00, 8'h01, TISE_ADDR_STAT2, 8'h01, 8'h00, 1'b0},
      '{3'd0, 8'h00, 8'h00, TISE_ADDR_STAT2, 8'h01, 8'h01, 1'b1},
      '{3'd1, 8'h00, 8'h08, TISE_ADDR_STAT2, 8'h08, 8'h00, 1'b0},
      '{3'd2, 8'h80, 8'h00, TISE_ADDR_STAT1, 8'h80, 8'h00, 1'b0},
      '{3'd3, 8'h08, 8'h00, TISE_ADDR_STAT1, 8'h08, 8'h00, 1'b0},
      '{3'd4, 8'h04, 8'h00, TISE_ADDR_STAT1, 8'h04, 8'h00, 1'b0},
      '{3'd5, 8'h40, 8'h00, TISE_ADDR_STAT1, 8'h40, 8'h40, 1'b0},
      '{3'd6, 8'h00, 8'h00, TISE_ADDR_STAT1, 8'h20, 8'h20, 1'b1},
      '{3'd3, 8'h13, 8'h00, TISE_ADDR_STAT1, 8'h08, 8'h08, 1'b1}};

   always #10 hclk = ~hclk;

   tise_top #(.SETTLE_CYCLES(SC)) i_tise_top (.hclk(hclk), .hresetn(hresetn),
      .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .wut_expire(evt[1]),
      .low_batt_event(evt[7]), .batt_ok(hclr[0]), .xtal_on(xtal),
      .tx_on(tx), .idle_state(idle), .por_detect(evt[0]),
      .fifo_err_event(evt[2]), .fifo_reset(hclr[1]),
      .tx_almost_full(evt[5]), .tx_almost_empty(evt[6]), .ext_event(evt[3]),
      .pkt_sent(evt[4]), .pkt_status_clr(hclr[2]), .interrupt_line_n(irq_n));
   tise_host i_tise_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));

   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      i_tise_host.xfer(1'b0, a, 32'h0, v);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [31:0] junk;
      i_tise_host.xfer(1'b1, a, {24'h0, v}, junk);
   endtask : wr

   // Level sources (full, empty) are left high until cleanup drops them
   task automatic fire(input logic [2:0] i);
      @(posedge hclk);
      evt[i] <= 1'b1;
      @(posedge hclk);
      if (i != 3'd5 && i != 3'd6)
         evt[i] <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask : fire

   task automatic cleanup;
      @(posedge hclk);
      evt <= 8'h00;
      hclr <= 3'h7;
      @(posedge hclk);
      hclr <= 3'h0;
      wr(TISE_ADDR_CLR1, 8'hff);
      wr(TISE_ADDR_CLR2, 8'hff);
   endtask : cleanup

   ////////////////////////////////////////////////////////////////////////////
   // Hang guard well above the few hundred cycles the sequence needs
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         give_verdict();
      end
   end

   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd(TISE_ADDR_EN1, d); chk(d, 32'h0);
      rd(TISE_ADDR_EN2, d); chk(d, 32'h3);
      rd(8'h20, d); chk(d, 32'h0);
      wr(TISE_ADDR_EN1, 8'hff); rd(TISE_ADDR_EN1, d); chk(d, 32'hec);
      foreach (rows[k])
      begin
         wr(TISE_ADDR_EN1, rows[k].en1);
         wr(TISE_ADDR_EN2, rows[k].en2);
         fire(rows[k].ev);
         chk(32'(irq_n), 32'(rows[k].irq));
         rd(rows[k].sa, d); chk(d, {24'h0, rows[k].exp1});
         rd(rows[k].sa, d); chk(d, {24'h0, rows[k].exp2});
         chk(32'(irq_n), 32'(~|(rows[k].exp2 & (rows[k].sa == TISE_ADDR_STAT2
            ? rows[k].en2 : rows[k].en1 & 8'hec))));
         cleanup();
      end
      // Low battery latched while masked, interrupts once enabled
      wr(TISE_ADDR_EN1, 8'h00); wr(TISE_ADDR_EN2, 8'h00); fire(3'd7);
      chk(32'(irq_n), 32'h1);
      wr(TISE_ADDR_EN2, 8'h04); repeat (3) @(posedge hclk);
      chk(32'(irq_n), 32'h0);
      // The line is registered one edge after the clearing read lands
      rd(TISE_ADDR_STAT2, d); chk(d, 32'h4);
      @(posedge hclk); chk(32'(irq_n), 32'h1);
      cleanup();
      // Module ready after settling, cleared by an enabled read, held until idle while masked
      wr(TISE_ADDR_EN2, 8'h02); xtal <= 1'b1; tx <= 1'b1;
      repeat (SC + 12) @(posedge hclk); chk(32'(irq_n), 32'h0);
      rd(TISE_ADDR_STAT2, d); chk(d, 32'h2);
      rd(TISE_ADDR_STAT2, d); chk(d, 32'h0);
      wr(TISE_ADDR_EN2, 8'h00); @(posedge hclk); idle <= 1'b1;
      @(posedge hclk); idle <= 1'b0; repeat (SC + 12) @(posedge hclk);
      rd(TISE_ADDR_STAT2, d); chk(d, 32'h2);
      rd(TISE_ADDR_STAT2, d); chk(d, 32'h2);
      @(posedge hclk); idle <= 1'b1; @(posedge hclk); idle <= 1'b0;
      rd(TISE_ADDR_STAT2, d); chk(d, 32'h0);
      xtal <= 1'b0; tx <= 1'b0; cleanup();
      // Line stays low until both groups are serviced
      wr(TISE_ADDR_EN1, 8'h08); wr(TISE_ADDR_EN2, 8'h01);
      fire(3'd0); fire(3'd3);
      rd(TISE_ADDR_STAT2, d); chk(d, 32'h1); chk(32'(irq_n), 32'h0);
      rd(TISE_ADDR_STAT1, d); chk(d, 32'h8);
      @(posedge hclk); chk(32'(irq_n), 32'h1);
      // A pulse arriving while ce is low is lost, since all state is frozen
      @(posedge hclk); ce <= 1'b0; fire(3'd0); ce <= 1'b1;
      chk(32'(irq_n), 32'h1);
      rd(TISE_ADDR_STAT2, d); chk(d, 32'h0);
      give_verdict();
   end
endmodule : testbench

bind tise_top tise_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_tise_monitor (
   .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .wut_expire(wut_expire), .por_detect(por_detect), .xtal_on(xtal_on),
   .tx_on(tx_on), .idle_state(idle_state),
   .interrupt_line_n(interrupt_line_n));

`default_nettype wire

/* tise_flag_bank.sv */
`timescale 1ns/1ps
`default_nettype none

// Eight sticky flags; a hardware set always beats any clear in the same cycle
module tise_flag_bank
(
   input wire logic hclk,          // Bus clock
   input wire logic hresetn,       // Async reset, active low
   input wire logic ce,            // Clock enable
   input wire logic [7:0] set_evt, // Set requests
   input wire logic [7:0] hw_clr,  // Hardware clears
   input wire logic [7:0] enable,  // Interrupt enables
   input wire logic rd_clr,        // Status register read
   input wire logic [7:0] sw_clr,  // Write-one clears
   output logic [7:0] flags        // Flag values
);
   import tise_pkg::*;

   tise_bank_state_t s_reg;
   tise_bank_state_t s_next;

   ////////////////////////////////////////////////////////////////////////////
   // Per-bit next value; masked bits ignore the read so they act as status
   always_comb
   begin
      s_next = s_reg;
      for (int i = 0; i < 8; i++)
      begin
         s_next.flag[i] = (s_reg.flag[i] & ~(rd_clr & enable[i])
                           & ~hw_clr[i] & ~sw_clr[i]) | set_evt[i];
      end
   end

   // State register, frozen while ce is low
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_reg <= '{flag: TISE_STAT_RST};
      else if (ce)
         s_reg <= s_next;
   end

   assign flags = s_reg.flag;

endmodule : tise_flag_bank

`default_nettype wire

/* tise_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Host side: single-word bus master that reads flags and writes enables
module tise_host
import tise_pkg::*;
(
   input wire logic hclk,          // Bus clock
   input wire logic hready,        // Bus ready
   input wire logic [31:0] hrdata, // Read data
   output logic hsel,              // Slave select
   output logic [31:0] haddr,      // Byte address
   output logic [1:0] htrans,      // Transfer type
   output logic hwrite,            // Write when high
   output logic [2:0] hsize,       // Always a word
   output logic [31:0] hwdata      // Write data
);
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
   end

   // Waits on hready rather than a fixed count; bench timeout ends a hang
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= TISE_HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      rd = hrdata;
      // Stale write data is inverted so nothing relies on it lingering
      hwdata <= ~wd;
   endtask : xfer
endmodule : tise_host

`default_nettype wire

/* tise_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

// Watches the bus and the interrupt line of the flag block from its ports
module tise_monitor
import tise_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = 8
)
(
   input wire logic hclk,            // Bus clock
   input wire logic hresetn,         // Async reset, active low
   input wire logic ce,              // Clock enable
   input wire logic hsel,            // Slave select
   input wire logic [31:0] haddr,    // Byte address
   input wire logic [1:0] htrans,    // Transfer type
   input wire logic hwrite,          // Write when high
   input wire logic [31:0] hwdata,   // Write data
   input wire logic hready,          // Bus ready
   input wire logic [31:0] hrdata,   // Read data
   input wire logic hreadyout,       // Slave ready
   input wire logic hresp,           // Response
   input wire logic wut_expire,      // Wake-up pulse
   input wire logic por_detect,      // Power-on pulse
   input wire logic xtal_on,         // Crystal on
   input wire logic tx_on,           // Transmit path on
   input wire logic idle_state,      // Idle state
   input wire logic interrupt_line_n // Interrupt, active low
);
   logic take;
   logic wr_en2_q;
   logic [3:0] en2_sh;
   logic [31:0] rdy_cnt;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////////////////////////////////////////
   // Shadow of enable two, so interrupt checks know which sources are live
   assign take = ce && hsel && hready && htrans == TISE_HTRANS_NONSEQ;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_en2_q <= 1'b0;
         en2_sh <= 4'h3;
         rdy_cnt <= 32'h0;
      end
      else if (ce)
      begin
         wr_en2_q <= take && hwrite && haddr[7:0] == TISE_ADDR_EN2;
         if (wr_en2_q)
            en2_sh <= hwdata[3:0];
         // Saturates past the check point so the check fires only once
         if (!(xtal_on && tx_on && !idle_state))
            rdy_cnt <= 32'h0;
         else if (rdy_cnt < SETTLE_CYCLES + 7)
            rdy_cnt <= rdy_cnt + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   hresp_okay_a:
      assert property (hresp == TISE_HRESP_OKAY) else $error("hresp not OKAY");
   zero_wait_a:
      assert property (hreadyout) else $error("hreadyout dropped");
   por_irq_a:
      assert property (ce && por_detect && en2_sh[0] |-> ##2 !interrupt_line_n)
         else $error("power-on event did not interrupt");
   wut_irq_a:
      assert property (ce && wut_expire && en2_sh[3] |-> ##2 !interrupt_line_n)
         else $error("wake-up event did not interrupt");
   rdy_irq_a:
      assert property (rdy_cnt == SETTLE_CYCLES + 6 && en2_sh[1]
         |-> !interrupt_line_n) else $error("ready did not interrupt");
   stat2_rsvd_a:
      assert property (take && !hwrite && haddr[7:0] == TISE_ADDR_STAT2
         |=> hrdata[31:4] == 28'h0) else $error("status two reserved set");
   en1_rsvd_a:
      assert property (take && !hwrite && haddr[7:0] == TISE_ADDR_EN1
         |=> (hrdata & 32'hffff_ff13) == 32'h0) else $error("enable one rsvd");
   reset_idle_a:
      assert property ($rose(hresetn) |-> interrupt_line_n)
         else $error("interrupt low after reset");
endmodule : tise_monitor

`default_nettype wire

/* tise_pkg.sv */
package tise_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices and byte addresses (byte address is four times index)
   localparam logic [7:0] TISE_IDX_STAT1 = 8'h03;
   localparam logic [7:0] TISE_IDX_STAT2 = 8'h04;
   localparam logic [7:0] TISE_IDX_EN1 = 8'h05;
   localparam logic [7:0] TISE_IDX_EN2 = 8'h06;
   localparam logic [7:0] TISE_IDX_CLR1 = 8'h10;
   localparam logic [7:0] TISE_IDX_CLR2 = 8'h11;
   localparam logic [7:0] TISE_ADDR_STAT1 = 8'(TISE_IDX_STAT1 * 4);
   localparam logic [7:0] TISE_ADDR_STAT2 = 8'(TISE_IDX_STAT2 * 4);
   localparam logic [7:0] TISE_ADDR_EN1 = 8'(TISE_IDX_EN1 * 4);
   localparam logic [7:0] TISE_ADDR_EN2 = 8'(TISE_IDX_EN2 * 4);
   localparam logic [7:0] TISE_ADDR_CLR1 = 8'(TISE_IDX_CLR1 * 4);
   localparam logic [7:0] TISE_ADDR_CLR2 = 8'(TISE_IDX_CLR2 * 4);

   ////////////////////////////////////////////////////////////////////////////
   // Bit positions, group two
   localparam int unsigned TISE_BIT_WUT = 3;
   localparam int unsigned TISE_BIT_LBD = 2;
   localparam int unsigned TISE_BIT_RDY = 1;
   localparam int unsigned TISE_BIT_POR = 0;
   // Bit positions, group one
   localparam int unsigned TISE_BIT_FERR = 7;
   localparam int unsigned TISE_BIT_AFULL = 6;
   localparam int unsigned TISE_BIT_AEMPTY = 5;
   localparam int unsigned TISE_BIT_EXT = 3;
   localparam int unsigned TISE_BIT_PKSENT = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and writable masks
   localparam logic [7:0] TISE_EN1_RST = 8'h00;
   localparam logic [7:0] TISE_EN2_RST = 8'h03;
   localparam logic [7:0] TISE_EN1_MASK = 8'hec;
   localparam logic [7:0] TISE_EN2_MASK = 8'h0f;
   localparam logic [7:0] TISE_STAT_RST = 8'h00;
   localparam logic [31:0] TISE_RDATA_RST = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: crystal settling time and its cycle count at the bus clock
   localparam int unsigned TISE_CLK_MHZ = 50;
   localparam int unsigned TISE_SETTLE_US = 1000;
   localparam int unsigned TISE_SETTLE_CYCLES = TISE_SETTLE_US * TISE_CLK_MHZ;

   ////////////////////////////////////////////////////////////////////////////
   // Bus encodings
   localparam logic [1:0] TISE_HTRANS_NONSEQ = 2'b10;
   localparam logic TISE_HRESP_OKAY = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // State records
   typedef struct packed {
      logic [7:0] flag;
   } tise_bank_state_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic ready;
      logic rise;
   } tise_settle_state_t;

   typedef struct packed {
      logic [7:0] en1;
      logic [7:0] en2;
      logic [31:0] rdata;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic irq_n;
      logic readyout;
      logic resp;
   } tise_top_state_t;

endpackage : tise_pkg

/* tise_settle_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// Module ready detection: crystal and transmit path on, then settling time
module tise_settle_timer #(
   parameter int unsigned SETTLE_CYCLES = 50000
)
(
   input wire logic hclk,     // Bus clock
   input wire logic hresetn,  // Async reset, active low
   input wire logic ce,       // Clock enable
   input wire logic xtal_on,  // Crystal enabled
   input wire logic tx_on,    // Transmit path enabled
   input wire logic idle,     // Device in idle state
   output logic ready_rise    // One-cycle pulse when ready is reached
);
   import tise_pkg::*;

   localparam logic [31:0] LAST = 32'(SETTLE_CYCLES - 1);

   tise_settle_state_t s_reg;
   tise_settle_state_t s_next;

   ////////////////////////////////////////////////////////////////////////////
   // Count settling cycles; dropping either enable or idling restarts it
   always_comb
   begin
      s_next = s_reg;
      s_next.rise = 1'b0;
      if (idle || !(xtal_on && tx_on))
      begin
         s_next.cnt = '0;
         s_next.ready = 1'b0;
      end
      else if (!s_reg.ready)
      begin
         if (s_reg.cnt >= LAST)
         begin
            s_next.ready = 1'b1;
            s_next.rise = 1'b1;
         end
         else
            s_next.cnt = s_reg.cnt + 32'h0000_0001;
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_reg <= '{cnt: 32'h0000_0000, ready: 1'b0, rise: 1'b0};
      else if (ce)
         s_reg <= s_next;
   end

   assign ready_rise = s_reg.rise;

endmodule : tise_settle_timer

`default_nettype wire

/* tise_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tise_top #(
   parameter int unsigned SETTLE_CYCLES = tise_pkg::TISE_SETTLE_CYCLES
)
(
   input wire logic hclk,            // Bus clock, 50 MHz
   input wire logic hresetn,         // Async reset, active low
   input wire logic ce,              // Clock enable, freezes all state
   input wire logic hsel,            // Slave select
   input wire logic [31:0] haddr,    // Byte address
   input wire logic [1:0] htrans,    // Transfer type
   input wire logic hwrite,          // Write when high
   input wire logic [2:0] hsize,     // Transfer size, word only
   input wire logic [31:0] hwdata,   // Write data
   input wire logic hready,          // Bus ready
   output logic [31:0] hrdata,       // Read data
   output logic hreadyout,           // Slave ready
   output logic hresp,               // Always OKAY
   input wire logic wut_expire,      // Wake-up timer expired pulse
   input wire logic low_batt_event,  // Low battery detected pulse
   input wire logic batt_ok,         // Battery replaced, clears low battery
   input wire logic xtal_on,         // Crystal enabled
   input wire logic tx_on,           // Transmit path enabled
   input wire logic idle_state,      // Device in idle state
   input wire logic por_detect,      // Power-on reset detected pulse
   input wire logic fifo_err_event,  // FIFO overflow or underflow pulse
   input wire logic fifo_reset,      // FIFO reset, clears FIFO error
   input wire logic tx_almost_full,  // FIFO above almost full level
   input wire logic tx_almost_empty, // FIFO at or below almost empty level
   input wire logic ext_event,       // External pin event pulse
   input wire logic pkt_sent,        // Packet sent without abort pulse
   input wire logic pkt_status_clr,  // Leave FIFO mode or new transmission
   output logic interrupt_line_n     // Interrupt to host, active low
);
   import tise_pkg::*;

   tise_top_state_t s_reg;
   tise_top_state_t s_next;

   logic addr_ok;
   logic rd_stat1;
   logic rd_stat2;
   logic [7:0] flags1;
   logic [7:0] flags2;
   logic [7:0] set1;
   logic [7:0] set2;
   logic [7:0] hwclr1;
   logic [7:0] hwclr2;
   logic [7:0] swclr1;
   logic [7:0] swclr2;
   logic [7:0] en1_now;
   logic [7:0] en2_now;
   logic rdy_rise;

   ////////////////////////////////////////////////////////////////////////////
   // Bus address phase; a transfer counts only when the bus is ready
   assign addr_ok = hsel && hready && (htrans == TISE_HTRANS_NONSEQ);
   assign rd_stat1 = ce && addr_ok && !hwrite
                     && (haddr[7:0] == TISE_ADDR_STAT1);
   assign rd_stat2 = ce && addr_ok && !hwrite
                     && (haddr[7:0] == TISE_ADDR_STAT2);

   // Enable values after any write landing at this edge; reads see them too
   always_comb
   begin
      en1_now = s_reg.en1;
      en2_now = s_reg.en2;
      if (s_reg.wr_pend && s_reg.wr_addr == TISE_ADDR_EN1)
         en1_now = hwdata[7:0] & TISE_EN1_MASK;
      if (s_reg.wr_pend && s_reg.wr_addr == TISE_ADDR_EN2)
         en2_now = hwdata[7:0] & TISE_EN2_MASK;
   end

   // Write-one clears from the data phase of a clear-register write
   assign swclr1 = (s_reg.wr_pend && s_reg.wr_addr == TISE_ADDR_CLR1) ?
                   hwdata[7:0] & TISE_EN1_MASK : 8'h00;
   assign swclr2 = (s_reg.wr_pend && s_reg.wr_addr == TISE_ADDR_CLR2) ?
                   hwdata[7:0] & TISE_EN2_MASK : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Group two event sources
   always_comb
   begin
      set2 = 8'h00;
      hwclr2 = 8'h00;
      set2[TISE_BIT_WUT] = wut_expire;
      set2[TISE_BIT_LBD] = low_batt_event;
      hwclr2[TISE_BIT_LBD] = batt_ok;
      set2[TISE_BIT_RDY] = rdy_rise;
      hwclr2[TISE_BIT_RDY] = idle_state;
      set2[TISE_BIT_POR] = por_detect;
   end

   // Group one event sources; FIFO level flags track their levels
   always_comb
   begin
      set1 = 8'h00;
      hwclr1 = 8'h00;
      set1[TISE_BIT_FERR] = fifo_err_event;
      hwclr1[TISE_BIT_FERR] = fifo_reset;
      set1[TISE_BIT_AFULL] = tx_almost_full;
      hwclr1[TISE_BIT_AFULL] = !tx_almost_full;
      set1[TISE_BIT_AEMPTY] = tx_almost_empty;
      hwclr1[TISE_BIT_AEMPTY] = !tx_almost_empty;
      set1[TISE_BIT_EXT] = ext_event;
      set1[TISE_BIT_PKSENT] = pkt_sent;
      hwclr1[TISE_BIT_PKSENT] = pkt_status_clr;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flag storage for both status registers
   tise_flag_bank u_bank_one (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .set_evt(set1),
      .hw_clr(hwclr1),
      .enable(s_reg.en1),
      .rd_clr(rd_stat1),
      .sw_clr(swclr1),
      .flags(flags1)
   );

   tise_flag_bank u_bank_two (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .set_evt(set2),
      .hw_clr(hwclr2),
      .enable(s_reg.en2),
      .rd_clr(rd_stat2),
      .sw_clr(swclr2),
      .flags(flags2)
   );

   // Crystal settling; the count is long, so a bench may shorten it
   tise_settle_timer #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_settle (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .xtal_on(xtal_on),
      .tx_on(tx_on),
      .idle(idle_state),
      .ready_rise(rdy_rise)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register file, read capture and interrupt line
   always_comb
   begin
      s_next = s_reg;
      s_next.en1 = en1_now;
      s_next.en2 = en2_now;
      s_next.readyout = 1'b1;
      s_next.resp = TISE_HRESP_OKAY;
      s_next.wr_pend = 1'b0;
      // Read data sampled in the address phase, shown in the data phase
      if (addr_ok)
      begin
         s_next.wr_pend = hwrite;
         s_next.wr_addr = haddr[7:0];
         s_next.rdata = 32'h0000_0000;
         if (!hwrite)
         begin
            unique case (haddr[7:0])
               TISE_ADDR_STAT1: s_next.rdata[7:0] = flags1;
               TISE_ADDR_STAT2: s_next.rdata[7:0] = flags2;
               TISE_ADDR_EN1: s_next.rdata[7:0] = en1_now;
               TISE_ADDR_EN2: s_next.rdata[7:0] = en2_now;
               default: s_next.rdata = 32'h0000_0000;
            endcase
         end
      end
      // Level output: held low while anything enabled is pending
      s_next.irq_n = ~|((flags1 & s_reg.en1) | (flags2 & s_reg.en2));
   end

   // Enables come out of reset with only ready and power-on unmasked
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_reg <= '{en1: TISE_EN1_RST,
                    en2: TISE_EN2_RST,
                    rdata: TISE_RDATA_RST,
                    wr_pend: 1'b0,
                    wr_addr: 8'h00,
                    irq_n: 1'b1,
                    readyout: 1'b1,
                    resp: TISE_HRESP_OKAY};
      else if (ce)
         s_reg <= s_next;
   end

   assign hrdata = s_reg.rdata;
   assign hreadyout = s_reg.readyout;
   assign hresp = s_reg.resp;
   assign interrupt_line_n = s_reg.irq_n;

endmodule : tise_top

`default_nettype wire

/* tise_top_note_unused.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
